// >>> lfs_config.sv
// Purpose: lock byte, fuse bytes, shadow latch, signature row and trim load
// Assumes: programming front end decodes strobes; memory erase is external
// Notes:   non-volatile cells are modelled as flops reset to factory values
//          a chip erase that never completes keeps the lock bits in force
//
// Functional notes
// - two lock bits, only chip erase restores
// - mode 1: no protection
// - mode 2: writes and fuse changes refused
// - mode 3: writes and verify reads blocked
// - fuses read programmed 0, unprogrammed 1
// - high fuse byte layout, unused bits read 1
// - low fuse byte layout and defaults
// - default clock source is 1 MHz RC
// - serial mode hides serial-enable fuse
// - eeprom keep fuse controls eeprom erase
// - chip erase leaves fuses unchanged
// - fuses latch on programming entry
// - eeprom keep acts immediately
// - fuses latch at power-up normal mode
// - three signature bytes, always readable
// - four calibration bytes at 0 to 3
// - trim takes 1 MHz calibration one clock after reset
// - lock bits restored after memory erase
// - chip erase command is 1000 0000
`timescale 1ns/1ps
`include "lfs_consts.svh"
module lfs_config #(
    parameter logic [7:0] SIG_MAKER = 8'hA5,  // arbitrary identity value
    parameter logic [7:0] SIG_SIZE  = 8'h5A,  // arbitrary identity value
    parameter logic [7:0] SIG_PART  = 8'h3C,  // arbitrary identity value
    parameter logic [7:0] CAL_1MHZ  = 8'h80,
    parameter logic [7:0] CAL_2MHZ  = 8'h80,
    parameter logic [7:0] CAL_4MHZ  = 8'h80,
    parameter logic [7:0] CAL_8MHZ  = 8'h80
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,            // power-on reset
    input  wire logic       prog_mode_i,      // level: in programming mode
    input  wire logic       serial_mode_i,    // level: programming over serial
    input  wire logic       cmd_load_i,       // pulse: command byte on data_i
    input  wire logic       write_i,          // pulse: execute loaded write
    input  wire logic       read_i,           // pulse: execute loaded read
    input  wire logic [1:0] addr_i,           // signature or fuse select
    input  wire logic [7:0] data_i,           // command or write data
    input  wire logic       mem_erase_done_i, // pulse: flash fully erased
    input  wire logic       mem_write_req_i,  // request to write flash/eeprom
    input  wire logic       mem_read_req_i,   // request to verify flash/eeprom
    output logic      [7:0] rdata_o,          // read data
    output logic            rdata_valid_o,    // pulse: rdata_o updated
    output logic            ready_o,          // high when no erase runs
    output logic            mem_erase_o,      // level: erase flash now
    output logic            eeprom_erase_o,   // level: erase eeprom now
    output logic            mem_write_ok_o,
    output logic            mem_read_ok_o,
    output logic      [7:0] osc_trim_register_o,
    output logic      [3:0] clock_source_fuses_o,
    output logic      [1:0] startup_time_fuses_o,
    output logic            pll_clock_fuse_o,
    output logic            osc_option_fuse_o,
    output logic            reset_pin_disable_fuse_o,
    output logic            brownout_enable_fuse_o,
    output logic            brownout_level_fuse_o,
    output logic            eeprom_keep_fuse_o
);
    // ==========================================================
    // storage
    logic [7:0] memory_lock_byte_reg;   // non-volatile lock byte
    logic [7:0] fuse_upper_byte_reg;    // non-volatile high fuses
    logic [7:0] fuse_lower_byte_reg;    // non-volatile low fuses
    logic [7:0] shadow_hi_reg;          // latched high fuses
    logic [7:0] shadow_lo_reg;          // latched low fuses
    logic [7:0] cmd_reg;                // last loaded command
    logic       prog_d_reg;             // previous prog_mode_i
    logic       trim_loaded_reg;        // trim copied after reset
    logic [7:0] osc_trim_reg;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    lfs_pkg::lfs_erase_t erase_reg;
    lfs_pkg::lfs_erase_t erase_next;
    // ==========================================================
    // decode
    wire lock_lo = memory_lock_byte_reg[`LFS_LOCK_LOW_BIT];
    wire lock_hi = memory_lock_byte_reg[`LFS_LOCK_HIGH_BIT];
    // the lower lock bit alone decides whether writes are allowed; the upper
    // one only matters once the lower one is programmed
    lfs_pkg::lfs_mode_t mode;
    assign mode = lock_lo ? lfs_pkg::LFS_MODE_OPEN
                : (lock_hi ? lfs_pkg::LFS_MODE_NOWRITE
                           : lfs_pkg::LFS_MODE_NOVERIFY);
    wire locked_wr  = (mode != lfs_pkg::LFS_MODE_OPEN);
    wire locked_rd  = (mode == lfs_pkg::LFS_MODE_NOVERIFY);
    wire idle       = (erase_reg == lfs_pkg::LFS_ER_IDLE);
    wire do_erase   = prog_mode_i && write_i && idle
                    && (cmd_reg == `LFS_CMD_CHIP_ERASE);
    wire do_fuse_wr = prog_mode_i && write_i && idle && !locked_wr
                    && (cmd_reg == `LFS_CMD_WRITE_FUSE);
    wire do_lock_wr = prog_mode_i && write_i && idle
                    && (cmd_reg == `LFS_CMD_WRITE_LOCK);
    wire wr_hi      = do_fuse_wr && (addr_i == `LFS_FUSE_SEL_HIGH);
    wire wr_lo      = do_fuse_wr && (addr_i == `LFS_FUSE_SEL_LOW);
    // serial mode may not alter the serial-enable fuse
    wire [7:0] hi_keep_mask = serial_mode_i ? (8'h01 << `LFS_HI_SERPROG_BIT) : 8'h00;
    // unused high bits are forced to 1 so they never read as programmed
    wire [7:0] hi_wr_val = (((data_i & ~hi_keep_mask)
                           | (fuse_upper_byte_reg & hi_keep_mask))
                           | `LFS_HI_UNUSED_MASK);
    // lock write may only program bits (1 to 0), never erase them
    wire [7:0] lock_wr_val = memory_lock_byte_reg & data_i;
    // latch on programming entry; power-up latch comes from reset
    // the power-up latch needs no edge: the reset values are the latched ones
    wire prog_entry = prog_mode_i && !prog_d_reg;
    wire prog_exit  = !prog_mode_i && prog_d_reg;
    // ==========================================================
    // fuse and lock cells; chip erase never touches the fuse bytes
    // limitation: reset restores factory values, so no retention is modelled
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fuse_upper_byte_reg  <= `LFS_HI_RESET;
            fuse_lower_byte_reg  <= `LFS_LO_RESET;
            memory_lock_byte_reg <= `LFS_LOCK_RESET;
        end
        else
        begin
            if (wr_hi)
                fuse_upper_byte_reg <= hi_wr_val;
            if (wr_lo)
                fuse_lower_byte_reg <= data_i;
            // lock bits return to 1 only at the end of a chip erase
            if (erase_reg == lfs_pkg::LFS_ER_LOCK)
                memory_lock_byte_reg <= `LFS_LOCK_RESET;
            else if (do_lock_wr)
                memory_lock_byte_reg <= lock_wr_val;
        end
    end
    // ==========================================================
    // shadow copy: reset models the power-up latch
    // both edges latch: entry captures the cells, exit publishes the edits
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shadow_hi_reg <= `LFS_HI_RESET;
            shadow_lo_reg <= `LFS_LO_RESET;
            prog_d_reg    <= 1'b0;
        end
        else
        begin
            prog_d_reg <= prog_mode_i;
            // entry latches; exit applies any changes made inside
            if (prog_entry || prog_exit)
            begin
                shadow_hi_reg <= fuse_upper_byte_reg;
                shadow_lo_reg <= fuse_lower_byte_reg;
            end
        end
    end
    // ==========================================================
    // erase sequencer: flash first, then locks
    // limitation: the flash side is awaited with no time limit; protection
    // stays in force until the lock state, so a cut erase leaves nothing open
    always_comb
    begin
        erase_next = erase_reg;
        case (erase_reg)
            lfs_pkg::LFS_ER_IDLE: if (do_erase) erase_next = lfs_pkg::LFS_ER_MEM;
            lfs_pkg::LFS_ER_MEM:  if (mem_erase_done_i) erase_next = lfs_pkg::LFS_ER_LOCK;
            lfs_pkg::LFS_ER_LOCK: erase_next = lfs_pkg::LFS_ER_IDLE;
            default:              erase_next = lfs_pkg::LFS_ER_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            erase_reg <= lfs_pkg::LFS_ER_IDLE;
        else
            erase_reg <= erase_next;
    end
    // ==========================================================
    // command register and read path
    // the command stays loaded, so many reads or writes may follow one load
    wire [7:0] sig_val = (addr_i == `LFS_SIG_ADDR_0) ? SIG_MAKER
                       : (addr_i == `LFS_SIG_ADDR_1) ? SIG_SIZE
                       : (addr_i == `LFS_SIG_ADDR_2) ? SIG_PART : 8'hFF;
    wire [7:0] cal_val = (addr_i == `LFS_SIG_ADDR_0) ? CAL_1MHZ
                       : (addr_i == `LFS_SIG_ADDR_1) ? CAL_2MHZ
                       : (addr_i == `LFS_SIG_ADDR_2) ? CAL_4MHZ : CAL_8MHZ;
    // serial mode sees the serial-enable fuse as unprogrammed
    wire [7:0] hi_rd = fuse_upper_byte_reg | hi_keep_mask;
    wire [7:0] fuse_val = (addr_i == `LFS_FUSE_SEL_LOW)  ? fuse_lower_byte_reg
                        : (addr_i == `LFS_FUSE_SEL_HIGH) ? hi_rd
                        : memory_lock_byte_reg;
    // signature row read: data_i[0] picks calibration (high byte)
    wire [7:0] rd_val = (cmd_reg == `LFS_CMD_READ_SIG)
                      ? (data_i[0] ? cal_val : sig_val) : fuse_val;
    // reads ignore the lock bits: fuses and signature stay visible when locked
    wire rd_hit = prog_mode_i && read_i
                && ((cmd_reg == `LFS_CMD_READ_SIG) || (cmd_reg == `LFS_CMD_READ_FUSE));
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_reg    <= 8'h00;
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            if (cmd_load_i && prog_mode_i)
                cmd_reg <= data_i;
            rvalid_reg <= rd_hit;
            if (rd_hit)
                rdata_reg <= rd_val;
        end
    end
    // ==========================================================
    // trim register: 1 MHz byte copied right after reset
    // limitation: no trim write port here; other frequencies need software to
    // copy the matching calibration byte into the trim register itself
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            osc_trim_reg    <= 8'h00;
            trim_loaded_reg <= 1'b0;
        end
        else if (!trim_loaded_reg)
        begin
            osc_trim_reg    <= CAL_1MHZ;
            trim_loaded_reg <= 1'b1;
        end
    end
    // ==========================================================
    // outputs
    assign rdata_o        = rdata_reg;
    assign rdata_valid_o  = rvalid_reg;
    assign ready_o        = idle;
    assign mem_erase_o    = (erase_reg == lfs_pkg::LFS_ER_MEM);
    // keep fuse read live from the cell, not the shadow
    assign eeprom_keep_fuse_o = fuse_upper_byte_reg[`LFS_HI_EEKEEP_BIT];
    assign eeprom_erase_o = mem_erase_o && eeprom_keep_fuse_o;
    // grants are combinational so the memory side sees a lock change at once
    assign mem_write_ok_o = mem_write_req_i && !locked_wr && prog_mode_i;
    assign mem_read_ok_o  = mem_read_req_i && !locked_rd && prog_mode_i;
    assign osc_trim_register_o      = osc_trim_reg;
    assign clock_source_fuses_o     = shadow_lo_reg[3:0];
    assign startup_time_fuses_o     = shadow_lo_reg[5:4];
    assign pll_clock_fuse_o         = shadow_lo_reg[`LFS_LO_PLL_BIT];
    assign osc_option_fuse_o        = shadow_lo_reg[`LFS_LO_OSCOPT_BIT];
    assign reset_pin_disable_fuse_o = shadow_hi_reg[`LFS_HI_RSTDIS_BIT];
    assign brownout_enable_fuse_o   = shadow_hi_reg[`LFS_HI_BROWNOUT_ENABLE_FUSE_BIT];
    assign brownout_level_fuse_o    = shadow_hi_reg[`LFS_HI_BODLVL_BIT];
    // ==========================================================
    // checks
    a_lock_nowrite: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !lock_lo |-> !mem_write_ok_o)
        else $error("memory write allowed while locked");
    a_lock_noverify: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!lock_lo && !lock_hi) |-> !mem_read_ok_o)
        else $error("verify read allowed in mode 3");
    a_open_access: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (lock_lo && lock_hi && prog_mode_i && mem_read_req_i) |-> mem_read_ok_o)
        else $error("read refused with no lock");
    a_fuse_locked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!lock_lo && write_i) |=> $stable(fuse_lower_byte_reg))
        else $error("fuse changed while locked");
    a_erase_keeps_fuse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mem_erase_o |=> $stable(fuse_upper_byte_reg))
        else $error("fuse changed during chip erase");
    a_lock_after_mem: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(lock_lo) |-> $past(mem_erase_o, 2))
        else $error("lock restored before flash erased");
    a_shadow_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (prog_mode_i && prog_d_reg) ##1 prog_mode_i |-> $stable(shadow_lo_reg))
        else $error("shadow changed inside programming mode");
    a_trim_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(trim_loaded_reg) |-> osc_trim_register_o == CAL_1MHZ)
        else $error("trim not loaded with 1 MHz byte");
    a_serial_hide: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (rd_hit && serial_mode_i && cmd_reg == `LFS_CMD_READ_FUSE
         && addr_i == `LFS_FUSE_SEL_HIGH) |=> rdata_o[`LFS_HI_SERPROG_BIT])
        else $error("serial enable fuse visible in serial mode");
    // each check below watches design state only, never bench timing
    // lock bits may only go from 1 to 0 outside the lock restore state
    a_lock_program_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (erase_reg != lfs_pkg::LFS_ER_LOCK) |=> ((memory_lock_byte_reg & ~$past(memory_lock_byte_reg)) == 8'h00))
        else $error("lock bit erased without chip erase");
    // unused high fuse bits always hold 1
    a_hi_unused_ones: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (fuse_upper_byte_reg & `LFS_HI_UNUSED_MASK) == `LFS_HI_UNUSED_MASK)
        else $error("unused high fuse bit programmed");
    // lock bits are untouched while the flash is still being erased
    a_erase_locks_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (erase_reg == lfs_pkg::LFS_ER_MEM) |=> $stable(memory_lock_byte_reg))
        else $error("lock bits changed during flash erase");
    // high shadow holds inside programming mode as the low one does
    a_shadow_hi_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (prog_mode_i && prog_d_reg) ##1 prog_mode_i |-> $stable(shadow_hi_reg))
        else $error("high shadow changed inside programming mode");
    // trim keeps its loaded value until the next reset
    a_trim_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        trim_loaded_reg |=> $stable(osc_trim_register_o))
        else $error("trim changed after reset load");
endmodule : lfs_config

// >>> lfs_config_tb_top.sv
// Purpose: self-checking bench for lock bits, fuse bytes, latching and signature row
// Assumes: programmer model drives strobes; the bench plays the flash erase side
// Notes:   signature and calibration values are arbitrary bench choices
`timescale 1ns/1ps
module lfs_config_tb_top;
    // ==========================================================
    // stimulus and observation nets
    logic       clk_sys_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       done      = 1'b0;  // flash erase finished pulse
    logic       wreq      = 1'b1;  // flash write request held up
    logic       rreq      = 1'b1;  // flash verify request held up
    logic       pm, sm, cl, wr, rd;
    logic [1:0] ad;
    logic [7:0] dt, rdata, trim;
    logic       vld, rdy, mer, eer, wok, rok, pll, oso, rsd, boe, bol, kep;
    logic [3:0] cks;
    logic [1:0] sut;
    int         miscompares = 0;
    int         check_count = 0;
    // arbitrary identity and calibration values, all distinct
    localparam logic [7:0] SIG [3] = '{8'hC3, 8'h4D, 8'h27};
    localparam logic [7:0] CAL [4] = '{8'h6B, 8'h72, 8'h8D, 8'h94};
    always #4 clk_sys_i = ~clk_sys_i;  // 125 MHz
    // ==========================================================
    // device and programmer
    lfs_config #(.SIG_MAKER(SIG[0]), .SIG_SIZE(SIG[1]), .SIG_PART(SIG[2]),
        .CAL_1MHZ(CAL[0]), .CAL_2MHZ(CAL[1]), .CAL_4MHZ(CAL[2]), .CAL_8MHZ(CAL[3])) DUT (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .prog_mode_i(pm), .serial_mode_i(sm),
        .cmd_load_i(cl), .write_i(wr), .read_i(rd), .addr_i(ad), .data_i(dt),
        .mem_erase_done_i(done), .mem_write_req_i(wreq), .mem_read_req_i(rreq),
        .rdata_o(rdata), .rdata_valid_o(vld), .ready_o(rdy), .mem_erase_o(mer),
        .eeprom_erase_o(eer), .mem_write_ok_o(wok), .mem_read_ok_o(rok),
        .osc_trim_register_o(trim), .clock_source_fuses_o(cks),
        .startup_time_fuses_o(sut), .pll_clock_fuse_o(pll), .osc_option_fuse_o(oso),
        .reset_pin_disable_fuse_o(rsd), .brownout_enable_fuse_o(boe),
        .brownout_level_fuse_o(bol), .eeprom_keep_fuse_o(kep));
    lfs_prog_model PGM (
        .clk_sys_i(clk_sys_i), .rdata_i(rdata), .rdata_valid_i(vld), .ready_i(rdy),
        .prog_mode_o(pm), .serial_mode_o(sm), .cmd_load_o(cl), .write_o(wr),
        .read_o(rd), .addr_o(ad), .data_o(dt));
    // ==========================================================
    // comparison, access and verdict tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // read one byte and demand its valid pulse
    task automatic rd_chk(input string what, input logic [7:0] cmd, input logic [1:0] a,
                          input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] v;
        logic       ok;
        PGM.rd(cmd, a, d, v, ok);
        check("rdata_valid", {7'h00, ok}, 8'h01);
        check(what, v, exp);
    endtask : rd_chk
    task automatic fuse_wr(input logic [1:0] a, input logic [7:0] d);
        PGM.strobe(0, a, 8'h40);
        PGM.strobe(1, a, d);
    endtask : fuse_wr
    // lock bits need their own write command, not the fuse one
    task automatic lock_wr(input logic [7:0] d);
        PGM.strobe(0, 2'h2, 8'h20);
        PGM.strobe(1, 2'h2, d);
    endtask : lock_wr
    // chip erase with the flash side answering after a few cycles
    task automatic erase(input logic exp_ee);
        logic ok;
        PGM.strobe(0, 2'h0, 8'h80);
        PGM.strobe(1, 2'h0, 8'h00);
        @(posedge clk_sys_i);
        #1;
        check("mem_erase", {7'h00, mer}, 8'h01);
        check("eeprom_erase", {7'h00, eer}, {7'h00, exp_ee});
        repeat (5) @(posedge clk_sys_i);
        #1;
        check("ready_in_erase", {7'h00, rdy}, 8'h00);
        @(negedge clk_sys_i);
        done = 1'b1;
        @(negedge clk_sys_i);
        done = 1'b0;
        PGM.wait_ready(4, ok);
        check("ready_after", {7'h00, ok}, 8'h01);
        rd_chk("lock_erased", 8'h04, 2'h2, 8'h00, 8'hFF);
    endtask : erase
    task automatic final_report;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // ==========================================================
    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        #160000;
        miscompares++;
        final_report();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(posedge clk_sys_i);
        #1;
        check("trim", trim, CAL[0]);
        check("clock_source", {4'h0, cks}, 8'h01);
        check("startup", {6'h00, sut}, 8'h02);
        check("pll_osc", {6'h00, pll, oso}, 8'h03);
        PGM.set_mode(1'b1, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            rd_chk("signature", 8'h08, 2'(i), 8'h00, (i < 3) ? SIG[i] : 8'hFF);
            rd_chk("calibration", 8'h08, 2'(i), 8'h01, CAL[i]);
        end
        rd_chk("fuse_low", 8'h04, 2'h0, 8'h00, 8'hE1);
        rd_chk("fuse_high", 8'h04, 2'h1, 8'h00, 8'hF7);
        rd_chk("lock", 8'h04, 2'h2, 8'h00, 8'hFF);
        // serial mode hides the serial-enable fuse and cannot unprogram it
        PGM.set_mode(1'b1, 1'b1);
        rd_chk("fuse_high_serial", 8'h04, 2'h1, 8'h00, 8'hFF);
        fuse_wr(2'h1, 8'hFF);
        PGM.set_mode(1'b1, 1'b0);
        rd_chk("fuse_high_par", 8'h04, 2'h1, 8'h00, 8'hF7);
        // new fuse values stay unseen by the clock logic until exit
        fuse_wr(2'h0, 8'hE4);
        fuse_wr(2'h1, 8'h02);
        check("cks_held", {4'h0, cks}, 8'h01);
        check("rsd_held", {7'h00, rsd}, 8'h01);
        check("keep_now", {7'h00, kep}, 8'h00);
        rd_chk("fuse_low_new", 8'h04, 2'h0, 8'h00, 8'hE4);
        rd_chk("fuse_high_new", 8'h04, 2'h1, 8'h00, 8'hE2);
        PGM.set_mode(1'b0, 1'b0);
        @(posedge clk_sys_i);
        #1;
        check("cks_applied", {4'h0, cks}, 8'h04);
        check("bod_applied", {6'h00, boe, bol}, 8'h01);
        check("rsd_applied", {7'h00, rsd}, 8'h00);
        // reset pin now disabled: only parallel programming from here on
        PGM.set_mode(1'b1, 1'b0);
        // fuses are final before any lock bit is programmed
        lock_wr(8'hFC);
        rd_chk("lock_mode3", 8'h04, 2'h2, 8'h00, 8'hFC);
        check("grants_mode3", {6'h00, wok, rok}, 8'h00);
        fuse_wr(2'h0, 8'hE1);
        rd_chk("fuse_locked3", 8'h04, 2'h0, 8'h00, 8'hE4);
        erase(1'b0);
        rd_chk("fuse_low_kept", 8'h04, 2'h0, 8'h00, 8'hE4);
        rd_chk("fuse_high_kept", 8'h04, 2'h1, 8'h00, 8'hE2);
        lock_wr(8'hFE);
        check("grants_mode2", {6'h00, wok, rok}, 8'h01);
        fuse_wr(2'h1, 8'hF7);
        rd_chk("fuse_locked2", 8'h04, 2'h1, 8'h00, 8'hE2);
        erase(1'b0);
        check("grants_mode1", {6'h00, wok, rok}, 8'h03);
        fuse_wr(2'h1, 8'hF7);
        check("keep_cleared", {7'h00, kep}, 8'h01);
        erase(1'b1);
        final_report();
    end
endmodule : lfs_config_tb_top

// >>> lfs_consts.svh
// Purpose: constants for the lock, fuse and signature configuration block
// Assumes: included by lfs_config.sv, not by lfs_pkg.sv
// Notes:   programmed fuse or lock bit reads 0, unprogrammed reads 1
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
// ==========================================================
// lock byte
`define LFS_LOCK_LOW_BIT     0
`define LFS_LOCK_HIGH_BIT    1
`define LFS_LOCK_RESET       8'hFF
// ==========================================================
// high fuse byte fields
`define LFS_HI_RSTDIS_BIT    4
`define LFS_HI_SERPROG_BIT   3
`define LFS_HI_EEKEEP_BIT    2
`define LFS_HI_BODLVL_BIT    1
`define LFS_HI_BROWNOUT_ENABLE_FUSE_BIT     0
`define LFS_HI_UNUSED_MASK   8'hE0
`define LFS_HI_RESET         8'hF7
// ==========================================================
// low fuse byte fields
`define LFS_LO_PLL_BIT       7
`define LFS_LO_OSCOPT_BIT    6
`define LFS_LO_RESET         8'hE1
`define LFS_CKSEL_RC_1MHZ    4'h1
// ==========================================================
// commands and address space
`define LFS_CMD_CHIP_ERASE   8'h80
`define LFS_CMD_WRITE_FUSE   8'h40
`define LFS_CMD_WRITE_LOCK   8'h20
`define LFS_CMD_READ_SIG     8'h08
`define LFS_CMD_READ_FUSE    8'h04
`define LFS_SIG_ADDR_0       2'h0
`define LFS_SIG_ADDR_1       2'h1
`define LFS_SIG_ADDR_2       2'h2
`define LFS_SIG_ADDR_3       2'h3
`define LFS_FUSE_SEL_LOW     2'h0
`define LFS_FUSE_SEL_HIGH    2'h1
`define LFS_FUSE_SEL_LOCK    2'h2
`endif

// >>> lfs_pkg.sv
// Purpose: types for the lock, fuse and signature configuration block
// Assumes: nothing
// Notes:   constants live in lfs_consts.svh
package lfs_pkg;
    // ==========================================================
    // protection mode decoded from the lock bits
    typedef enum logic [1:0] {
        LFS_MODE_OPEN,
        LFS_MODE_NOWRITE,
        LFS_MODE_NOVERIFY
    } lfs_mode_t;
    // erase sequencer states
    typedef enum logic [1:0] {
        LFS_ER_IDLE,
        LFS_ER_MEM,
        LFS_ER_LOCK
    } lfs_erase_t;
endpackage : lfs_pkg

// >>> lfs_prog_model.sv
// Purpose: programmer model that drives the command, strobe and data lines
// Assumes: strobes are taken on a rising edge while prog_mode_o is high
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
module lfs_prog_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_valid_i,
    input  wire logic       ready_i,
    output logic            prog_mode_o,
    output logic            serial_mode_o,
    output logic            cmd_load_o,
    output logic            write_o,
    output logic            read_o,
    output logic      [1:0] addr_o,
    output logic      [7:0] data_o
);
    // ==========================================================
    // idle levels from time zero
    initial
    begin
        prog_mode_o   = 1'b0;
        serial_mode_o = 1'b0;
        cmd_load_o    = 1'b0;
        write_o       = 1'b0;
        read_o        = 1'b0;
        addr_o        = 2'h0;
        data_o        = 8'h00;
    end
    // ==========================================================
    // mode pins change only off the sampling edge
    task automatic set_mode(input logic p, input logic s);
        @(negedge clk_sys_i);
        prog_mode_o   = p;
        serial_mode_o = s;
    endtask : set_mode
    // one strobe of kind 0 load, 1 write, 2 read; held across one taking edge
    task automatic strobe(input int kind, input logic [1:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o     = a;
        data_o     = d;
        cmd_load_o = (kind == 0);
        write_o    = (kind == 1);
        read_o     = (kind == 2);
        @(negedge clk_sys_i);
        cmd_load_o = 1'b0;
        write_o    = 1'b0;
        read_o     = 1'b0;
        data_o     = ~d;  // a stale value must never pass for fresh data
    endtask : strobe
    // read: valid stands from the taking edge to the next one, so it is
    // sampled at the falling edge in between, where it is settled
    task automatic rd(input logic [7:0] cmd, input logic [1:0] a, input logic [7:0] d,
                      output logic [7:0] v, output logic ok);
        strobe(0, a, cmd);
        strobe(2, a, d);
        ok = rdata_valid_i;
        v  = rdata_i;
    endtask : rd
    // bounded wait for the end of an erase; a slow device is allowed
    task automatic wait_ready(input int limit, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < limit && !ok; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            ok = ready_i;
        end
    endtask : wait_ready
endmodule : lfs_prog_model
